// [src/bscan_cfg.svh]
`ifndef BSCAN_CFG_SVH
`define BSCAN_CFG_SVH

`define IR_LEN           10
`define IR_CAPTURE       10'h155
`define CODE_SAMPLE      10'h005
`define CODE_EXTEST      10'h00F
`define CODE_BYPASS      10'h3FF
`define CODE_USERCODE    10'h007
`define CODE_IDCODE      10'h006
`define CODE_HIGHZ       10'h00B
`define CODE_CLAMP       10'h00A
`define CODE_RECONFIG    10'h001
`define CODE_IO_SETUP    10'h00D
`define CODE_CLK_USER    10'h1EE
`define CODE_CLK_OSC     10'h2EE
`define CODE_IDLE        10'h2D0
`define CODE_ENGAGE      10'h2B0
`define CODE_BOOT        10'h270
`define CODE_UNLOCK      10'h281
`define CODE_KEY_LOAD    10'h1AD
`define CODE_KEY_CLR     10'h029

`define DR32_LEN         32
`define BOOT_LEN         22
`define KEY_LEN          512
`define PIN_COUNT        8
`define CELLS_PER_PIN    3
`define CELL_IN          0
`define CELL_OUT         1
`define CELL_OE          2
`define BSR_LEN          24
`define CLR_CNT_W        4
`define KEY_CLR_TCK      4'hA
`define TAP_W            7
`define SYNC_W           18

// identity fields: arbitrary neutral values
`define ID_VERSION       4'h0
`define ID_PART          16'h1234
`define ID_MAKER         11'h2A5
`define ID_LSB           1'h1

`endif

// [src/bscan_pkg.sv]
package bscan_pkg;

`include "bscan_cfg.svh"

    typedef enum logic [4:0] {
        INS_IDCODE              = 5'h00,
        INS_BYPASS              = 5'h01,
        INS_SAMPLE              = 5'h02,
        INS_EXTEST              = 5'h03,
        INS_USERCODE            = 5'h04,
        INS_HIGHZ               = 5'h05,
        INS_CLAMP               = 5'h06,
        INS_RECONFIG_PULSE      = 5'h07,
        INS_IO_SETUP            = 5'h08,
        INS_SELECT_USER_CLK     = 5'h09,
        INS_SELECT_INTERNAL_OSC = 5'h0A,
        INS_IDLE_BOOT_CTRL      = 5'h0B,
        INS_ENGAGE_BOOT_CTRL    = 5'h0C,
        INS_LOAD_BOOT_POINTER   = 5'h0D,
        INS_UNLOCK              = 5'h0E,
        INS_LOAD_VOLATILE_KEY   = 5'h0F,
        INS_CLEAR_KEY_VALID     = 5'h10
    } instr_e;

    typedef struct packed {
        logic reset;
        logic capture_ir;
        logic shift_ir;
        logic update_ir;
        logic capture_dr;
        logic shift_dr;
        logic update_dr;
    } tap_ctl_s;

    typedef struct packed {
        logic                    tck_prev;
        logic [`IR_LEN-1:0]      ir_sr;
        instr_e                  ins;
        logic                    unlocked;
        logic                    bypass;
        logic [`DR32_LEN-1:0]    dr32;
        logic [`BSR_LEN-1:0]     bsr_sr;
        logic [`BSR_LEN-1:0]     bsr_up;
        logic [`KEY_LEN-1:0]     key;
        logic                    key_valid;
        logic [`CLR_CNT_W-1:0]   clr_cnt;
        logic                    user_clk_sel;
        logic                    ctrl_idle;
        logic                    reconfig_pulse;
        logic                    config_abort;
        logic                    erase_config;
        logic                    boot_load;
        logic [`BOOT_LEN-1:0]    boot_addr;
        logic                    io_open;
        logic                    io_shift;
        logic                    io_data;
        logic                    tdo;
        logic                    tdo_oe;
        logic [`PIN_COUNT-1:0]   pad_out;
        logic [`PIN_COUNT-1:0]   pad_oe;
        logic [`PIN_COUNT-1:0]   pad_keep;
    } state_s;

endpackage

// [src/sync2.sv]
`timescale 1ns/10ps

module sync2 #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [1:0][W-1:0] st;
    logic [1:0][W-1:0] next_st;

    // stage 0 is only read by stage 1
    always_comb begin
        next_st[0] = d;
        next_st[1] = st[0];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st[1];

endmodule

// [src/instr_decode.sv]
`timescale 1ns/10ps
`include "bscan_cfg.svh"

module instr_decode (
    input  wire logic [`IR_LEN-1:0] code,
    input  wire logic               unlocked,
    input  wire logic               secure_variant,
    output bscan_pkg::instr_e       ins
);

    bscan_pkg::instr_e raw;

    always_comb begin
        case (code)
            `CODE_SAMPLE:   raw = bscan_pkg::INS_SAMPLE;
            `CODE_EXTEST:   raw = bscan_pkg::INS_EXTEST;
            `CODE_USERCODE: raw = bscan_pkg::INS_USERCODE;
            `CODE_IDCODE:   raw = bscan_pkg::INS_IDCODE;
            `CODE_HIGHZ:    raw = bscan_pkg::INS_HIGHZ;
            `CODE_CLAMP:    raw = bscan_pkg::INS_CLAMP;
            `CODE_RECONFIG: raw = bscan_pkg::INS_RECONFIG_PULSE;
            `CODE_IO_SETUP: raw = bscan_pkg::INS_IO_SETUP;
            `CODE_CLK_USER: raw = bscan_pkg::INS_SELECT_USER_CLK;
            `CODE_CLK_OSC:  raw = bscan_pkg::INS_SELECT_INTERNAL_OSC;
            `CODE_IDLE:     raw = bscan_pkg::INS_IDLE_BOOT_CTRL;
            `CODE_ENGAGE:   raw = bscan_pkg::INS_ENGAGE_BOOT_CTRL;
            `CODE_BOOT:     raw = secure_variant ? bscan_pkg::INS_BYPASS
                                                 : bscan_pkg::INS_LOAD_BOOT_POINTER;
            `CODE_UNLOCK:   raw = secure_variant ? bscan_pkg::INS_UNLOCK
                                                 : bscan_pkg::INS_BYPASS;
            `CODE_KEY_LOAD: raw = secure_variant ? bscan_pkg::INS_LOAD_VOLATILE_KEY
                                                 : bscan_pkg::INS_BYPASS;
            `CODE_KEY_CLR:  raw = secure_variant ? bscan_pkg::INS_CLEAR_KEY_VALID
                                                 : bscan_pkg::INS_BYPASS;
            default:        raw = bscan_pkg::INS_BYPASS;
        endcase
        ins = raw;
        // before unlock only the mandatory set and unlock itself pass
        if (secure_variant && !unlocked) begin
            case (raw)
                bscan_pkg::INS_BYPASS,
                bscan_pkg::INS_SAMPLE,
                bscan_pkg::INS_EXTEST,
                bscan_pkg::INS_UNLOCK: ins = raw;
                default:               ins = bscan_pkg::INS_BYPASS;
            endcase
        end
    end

endmodule

// [src/bscan_decoder.sv]
`timescale 1ns/10ps
`include "bscan_cfg.svh"

// Behaviour
// - sample code captures pin snapshot into boundary register, allows preload
// - external test drives pins from boundary register, captures inputs
// - bypass code puts one-bit bypass stage between serial in and out
// - usercode code shifts out the 32-bit user code
// - identification selected by its code and default after reset
// - high-impedance code selects bypass and floats every user pin
// - clamp code selects bypass, pins held from boundary register
// - enabled keeper or pull-up overrides float in highz, clamp, extest
// - reconfiguration pulse code starts reconfiguration, physical pin untouched
// - io setup code opens io setup chain; tester waits for status
// - io setup code interrupts any configuration in progress
// - clock select codes pick user clock pin or internal oscillator
// - idle code idles boot controllers, engage code re-engages them
// - boot pointer code loads 22-bit address; absent on secure variant
// - unlock code opens remaining codes, erases configuration and key
// - key load code shifts into 512-bit key chain, no output
// - key-valid clear needs code active ten scan clocks
// - bypass, identification and sample leave configuration undisturbed
// - secure variant accepts only mandatory codes and unlock before unlock
// - secure variant rejects loaded identification before unlock, keeps it as reset default
// - identification word: version, part, maker, lsb one, lsb first

module bscan_decoder #(
    parameter bit secure_variant = 1'b0
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   tck,
    input  wire logic                   tdi,
    input  wire bscan_pkg::tap_ctl_s    tap,
    input  wire logic [`PIN_COUNT-1:0]  pad_in,
    input  wire logic                   config_status_pin,
    input  wire logic [`PIN_COUNT-1:0]  core_out,
    input  wire logic [`PIN_COUNT-1:0]  core_oe,
    input  wire logic [`PIN_COUNT-1:0]  keeper_en,
    input  wire logic [`DR32_LEN-1:0]   user_code,
    input  wire logic                   io_chain_tdo,
    output logic                        tdo,
    output logic                        tdo_oe,
    output logic [`PIN_COUNT-1:0]       pad_out,
    output logic [`PIN_COUNT-1:0]       pad_oe,
    output logic [`PIN_COUNT-1:0]       pad_keep,
    output logic                        reconfig_pulse,
    output logic                        config_abort,
    output logic                        io_setup_shift_chain,
    output logic                        io_chain_shift,
    output logic                        io_chain_data,
    output logic                        user_clk_sel,
    output logic                        boot_ctrl_idle,
    output logic [`BOOT_LEN-1:0]        boot_addr,
    output logic                        boot_addr_load,
    output logic                        erase_config,
    output logic                        key_valid,
    output logic [`KEY_LEN-1:0]         volatile_key
);

    bscan_pkg::state_s    st;
    bscan_pkg::state_s    next_st;
    bscan_pkg::tap_ctl_s  tap_s;
    bscan_pkg::instr_e    dec;
    logic                 tck_s;
    logic                 tdi_s;
    logic                 status_s;
    logic [`PIN_COUNT-1:0] pad_in_s;
    logic                 rise;
    logic                 fall;
    logic [`BSR_LEN-1:0]  cap_cells;
    logic [`PIN_COUNT-1:0] up_out;
    logic [`PIN_COUNT-1:0] up_oe;
    logic                 pin_test;

    // every pin-side input passes two flops before use
    sync2 #(.W(`SYNC_W)) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       ({tck, tdi, tap, config_status_pin, pad_in}),
        .q       ({tck_s, tdi_s, tap_s, status_s, pad_in_s})
    );

    instr_decode u_dec (
        .code           (st.ir_sr),
        .unlocked       (st.unlocked),
        .secure_variant (secure_variant),
        .ins            (dec)
    );

    assign rise = tck_s & ~st.tck_prev;
    assign fall = ~tck_s & st.tck_prev;

    always_comb begin
        cap_cells = '0;
        up_out    = '0;
        up_oe     = '0;
        for (int i = 0; i < `PIN_COUNT; i++) begin
            cap_cells[i*`CELLS_PER_PIN+`CELL_IN]  = pad_in_s[i];
            cap_cells[i*`CELLS_PER_PIN+`CELL_OUT] = core_out[i];
            cap_cells[i*`CELLS_PER_PIN+`CELL_OE]  = core_oe[i];
            up_out[i] = st.bsr_up[i*`CELLS_PER_PIN+`CELL_OUT];
            up_oe[i]  = st.bsr_up[i*`CELLS_PER_PIN+`CELL_OE];
        end
    end

    assign pin_test = (st.ins == bscan_pkg::INS_EXTEST) || (st.ins == bscan_pkg::INS_CLAMP) ||
                      (st.ins == bscan_pkg::INS_HIGHZ);

    always_comb begin
        next_st                = st;
        next_st.tck_prev       = tck_s;
        next_st.reconfig_pulse = 1'b0;
        next_st.config_abort   = 1'b0;
        next_st.erase_config   = 1'b0;
        next_st.boot_load      = 1'b0;
        next_st.io_shift       = 1'b0;
        next_st.io_open        = (st.ins == bscan_pkg::INS_IO_SETUP);

        if (rise) begin
            if (tap_s.capture_ir) begin
                next_st.ir_sr = `IR_CAPTURE;
            end else if (tap_s.shift_ir) begin
                next_st.ir_sr = {tdi_s, st.ir_sr[`IR_LEN-1:1]};
            end
            if (tap_s.capture_dr) begin
                case (st.ins)
                    bscan_pkg::INS_SAMPLE,
                    bscan_pkg::INS_EXTEST: next_st.bsr_sr = cap_cells;
                    bscan_pkg::INS_IDCODE:
                        next_st.dr32 = {`ID_VERSION, `ID_PART, `ID_MAKER, `ID_LSB};
                    bscan_pkg::INS_USERCODE: next_st.dr32 = user_code;
                    bscan_pkg::INS_LOAD_BOOT_POINTER: begin
                        next_st.dr32                = '0;
                        next_st.dr32[`BOOT_LEN-1:0] = st.boot_addr;
                    end
                    bscan_pkg::INS_LOAD_VOLATILE_KEY,
                    bscan_pkg::INS_IO_SETUP: next_st.bypass = st.bypass;
                    default: next_st.bypass = 1'b0;
                endcase
            end else if (tap_s.shift_dr) begin
                case (st.ins)
                    bscan_pkg::INS_SAMPLE,
                    bscan_pkg::INS_EXTEST:
                        next_st.bsr_sr = {tdi_s, st.bsr_sr[`BSR_LEN-1:1]};
                    bscan_pkg::INS_IDCODE,
                    bscan_pkg::INS_USERCODE:
                        next_st.dr32 = {tdi_s, st.dr32[`DR32_LEN-1:1]};
                    bscan_pkg::INS_LOAD_BOOT_POINTER:
                        next_st.dr32[`BOOT_LEN-1:0] = {tdi_s, st.dr32[`BOOT_LEN-1:1]};
                    bscan_pkg::INS_LOAD_VOLATILE_KEY:
                        next_st.key = {tdi_s, st.key[`KEY_LEN-1:1]};
                    bscan_pkg::INS_IO_SETUP: begin
                        next_st.io_shift = 1'b1;
                        next_st.io_data  = tdi_s;
                    end
                    default: next_st.bypass = tdi_s;
                endcase
            end
            // key-valid falls only on the tenth scan clock with the code held
            if (st.ins == bscan_pkg::INS_CLEAR_KEY_VALID && st.clr_cnt != `KEY_CLR_TCK) begin
                next_st.clr_cnt = st.clr_cnt + `CLR_CNT_W'(1);
                if (next_st.clr_cnt == `KEY_CLR_TCK) begin
                    next_st.key_valid = 1'b0;
                end
            end
        end

        if (fall) begin
            next_st.tdo_oe = tap_s.shift_ir | tap_s.shift_dr;
            if (tap_s.shift_ir) begin
                next_st.tdo = st.ir_sr[0];
            end else begin
                case (st.ins)
                    bscan_pkg::INS_SAMPLE,
                    bscan_pkg::INS_EXTEST:            next_st.tdo = st.bsr_sr[0];
                    bscan_pkg::INS_IDCODE,
                    bscan_pkg::INS_USERCODE,
                    bscan_pkg::INS_LOAD_BOOT_POINTER: next_st.tdo = st.dr32[0];
                    // key chain end is deliberately not wired out
                    bscan_pkg::INS_LOAD_VOLATILE_KEY: next_st.tdo = 1'b0;
                    bscan_pkg::INS_IO_SETUP:          next_st.tdo = io_chain_tdo;
                    default:                          next_st.tdo = st.bypass;
                endcase
            end
            if (tap_s.update_ir) begin
                next_st.ins     = dec;
                next_st.clr_cnt = '0;
                case (dec)
                    bscan_pkg::INS_RECONFIG_PULSE: next_st.reconfig_pulse = 1'b1;
                    bscan_pkg::INS_IO_SETUP:       next_st.config_abort = 1'b1;
                    bscan_pkg::INS_SELECT_USER_CLK:     next_st.user_clk_sel = 1'b1;
                    bscan_pkg::INS_SELECT_INTERNAL_OSC: next_st.user_clk_sel = 1'b0;
                    bscan_pkg::INS_IDLE_BOOT_CTRL:      next_st.ctrl_idle = 1'b1;
                    bscan_pkg::INS_ENGAGE_BOOT_CTRL:    next_st.ctrl_idle = 1'b0;
                    bscan_pkg::INS_UNLOCK: begin
                        next_st.unlocked     = 1'b1;
                        next_st.erase_config = 1'b1;
                        next_st.key          = '0;
                        next_st.key_valid    = 1'b0;
                    end
                    default: next_st.clr_cnt = '0;
                endcase
            end else if (tap_s.update_dr) begin
                case (st.ins)
                    bscan_pkg::INS_SAMPLE,
                    bscan_pkg::INS_EXTEST: next_st.bsr_up = st.bsr_sr;
                    bscan_pkg::INS_LOAD_BOOT_POINTER: begin
                        next_st.boot_addr = st.dr32[`BOOT_LEN-1:0];
                        next_st.boot_load = 1'b1;
                    end
                    bscan_pkg::INS_LOAD_VOLATILE_KEY: next_st.key_valid = 1'b1;
                    default: next_st.boot_load = 1'b0;
                endcase
            end
        end

        // identification comes back on reset even while locked
        if (tap_s.reset) begin
            next_st.ins     = bscan_pkg::INS_IDCODE;
            next_st.clr_cnt = '0;
        end

        for (int i = 0; i < `PIN_COUNT; i++) begin
            case (st.ins)
                bscan_pkg::INS_EXTEST,
                bscan_pkg::INS_CLAMP: begin
                    next_st.pad_out[i] = up_out[i];
                    next_st.pad_oe[i]  = up_oe[i];
                end
                bscan_pkg::INS_HIGHZ: begin
                    next_st.pad_out[i] = 1'b0;
                    next_st.pad_oe[i]  = 1'b0;
                end
                default: begin
                    next_st.pad_out[i] = core_out[i];
                    next_st.pad_oe[i]  = core_oe[i];
                end
            endcase
            next_st.pad_keep[i] = pin_test & ~next_st.pad_oe[i] & keeper_en[i];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tdo                  = st.tdo;
    assign tdo_oe               = st.tdo_oe;
    assign pad_out              = st.pad_out;
    assign pad_oe               = st.pad_oe;
    assign pad_keep             = st.pad_keep;
    assign reconfig_pulse       = st.reconfig_pulse;
    assign config_abort         = st.config_abort;
    assign io_setup_shift_chain = st.io_open;
    assign io_chain_shift       = st.io_shift;
    assign io_chain_data        = st.io_data;
    assign user_clk_sel         = st.user_clk_sel;
    assign boot_ctrl_idle       = st.ctrl_idle;
    assign boot_addr            = st.boot_addr;
    assign boot_addr_load       = st.boot_load;
    assign erase_config         = st.erase_config;
    assign key_valid            = st.key_valid;
    assign volatile_key         = st.key;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    tap_reset_id_a: assert property (tap_s.reset |=> st.ins == bscan_pkg::INS_IDCODE)
        else $error("test logic reset did not select identification");
    bypass_capture_a: assert property (
        rise && tap_s.capture_dr && st.ins == bscan_pkg::INS_BYPASS |=> !st.bypass)
        else $error("bypass stage did not capture zero");
    highz_float_a: assert property (st.ins == bscan_pkg::INS_HIGHZ |=> st.pad_oe == '0)
        else $error("pin driven during high impedance");
    clamp_hold_a: assert property (
        st.ins == bscan_pkg::INS_CLAMP |=> st.pad_out == $past(up_out) && st.pad_oe == $past(up_oe))
        else $error("clamp pins differ from boundary update cells");
    keeper_mode_a: assert property (
        st.pad_keep != '0 |-> $past(pin_test) && (st.pad_keep & st.pad_oe) == '0)
        else $error("keeper asserted outside test modes or on driven pin");
    reconfig_once_a: assert property (
        fall && tap_s.update_ir && dec == bscan_pkg::INS_RECONFIG_PULSE
        |=> st.reconfig_pulse ##1 !st.reconfig_pulse)
        else $error("reconfiguration pulse not exactly one cycle");
    key_clear_a: assert property ($fell(st.key_valid) |->
        st.clr_cnt == `KEY_CLR_TCK || st.ins == bscan_pkg::INS_UNLOCK)
        else $error("key valid cleared before ten scan clocks");
    locked_set_a: assert property (secure_variant && !st.unlocked |->
        st.ins inside {bscan_pkg::INS_BYPASS, bscan_pkg::INS_SAMPLE,
                       bscan_pkg::INS_EXTEST, bscan_pkg::INS_IDCODE})
        else $error("locked device accepted a restricted instruction");
    id_lsb_a: assert property (
        rise && tap_s.capture_dr && st.ins == bscan_pkg::INS_IDCODE |=> st.dr32[0] == 1'b1)
        else $error("identification lsb not one");
    boot_secure_a: assert property (secure_variant |->
        st.ins != bscan_pkg::INS_LOAD_BOOT_POINTER)
        else $error("boot pointer reachable on secure variant");

endmodule

// [test/scan_tester.sv]
`timescale 1ns/10ps

module scan_tester (
    input  wire logic           ref_clk,
    input  wire logic           tdo,
    output bscan_pkg::tap_ctl_s tap,
    output logic                tck,
    output logic                tdi,
    output logic                done,
    output logic [31:0]         cap
);
    // tck idles high between frames, tdi idles at its pull-up level
    initial {tck, tdi, tap, done, cap} = {2'h3, 7'h00, 1'b0, 32'h0};

    // flags settle two cycles before the fall so they never race the tck edge
    task automatic cyc(input logic [6:0] st, input logic d, output logic q);
        tap = st;
        tdi = d;
        repeat (2) @(negedge ref_clk);
        tck = 1'b0;
        repeat (18) @(negedge ref_clk);
        q = tdo;
        tck = 1'b1;
        repeat (20) @(negedge ref_clk);
    endtask

    task automatic ir(input logic [9:0] c);
        logic q;
        for (int i = 0; i < 10; i++) cyc(7'h10, c[i], q);
        cyc(7'h08, 1'b1, q);
        cyc(7'h00, 1'b1, q);
    endtask

    task automatic dr(input int n, input logic [31:0] din);
        logic q;
        cap = '0;
        cyc(7'h04, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            cyc(7'h02, din[i], q);
            cap[i] = q;
        end
        cyc(7'h01, 1'b1, q);
        cyc(7'h00, 1'b1, q);
        done = 1'b1;
        @(negedge ref_clk);
        done = 1'b0;
    endtask
endmodule

// [test/bscan_decoder_tb.sv]
`timescale 1ns/10ps
`include "bscan_cfg.svh"

module bscan_decoder_tb;
    logic                ref_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                tck, tdi, tdo, done, reconfig_pulse, abort, io_open, io_shift, io_data;
    logic                clk_sel, ctl_idle, boot_ld, oe_tdo, erase, key_valid;
    logic [21:0]         boot_addr;
    logic [511:0]        volatile_key;
    logic [7:0]          n_abort, n_shift, n_load, n_erase;
    bscan_pkg::tap_ctl_s tap;
    logic [7:0]          pad_in, core_out, keeper_en, pad_out, pad_oe, pad_keep, n_pulse;
    logic [31:0]         user_code, cap, d, e, b;
    logic [31:0]         q_exp[$];
    logic [9:0]          codes[6] = '{`CODE_CLAMP, `CODE_HIGHZ, 10'h3A5, `CODE_BYPASS,
                                      `CODE_UNLOCK, `CODE_KEY_LOAD};
    int                  n_errors = 0;
    int                  num_checks = 0;
    integer              seed = 32'h141f;

    bscan_decoder i_bscan_decoder (.ref_clk, .rst_n, .tck, .tdi, .tap, .pad_in,
        .config_status_pin(1'b1), .core_out, .core_oe(8'hFF), .keeper_en, .user_code,
        .io_chain_tdo(1'b0), .tdo, .tdo_oe(oe_tdo), .pad_out, .pad_oe, .pad_keep,
        .reconfig_pulse, .config_abort(abort), .io_setup_shift_chain(io_open),
        .io_chain_shift(io_shift), .io_chain_data(io_data), .user_clk_sel(clk_sel),
        .boot_ctrl_idle(ctl_idle), .boot_addr, .boot_addr_load(boot_ld), .erase_config(erase),
        .key_valid, .volatile_key);
    scan_tester i_scan_tester (.ref_clk, .tdo, .tap, .tck, .tdi, .done, .cap);

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        num_checks++;
        if (g !== ex) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, g);
        end
    endtask

    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) n_pulse <= rst_n ? n_pulse + {7'h00, reconfig_pulse} : 8'h00;
    always @(posedge ref_clk) n_abort <= rst_n ? n_abort + {7'h00, abort} : 8'h00;
    always @(posedge ref_clk) n_shift <= rst_n ? n_shift + {7'h00, io_shift} : 8'h00;
    always @(posedge ref_clk) n_load <= rst_n ? n_load + {7'h00, boot_ld} : 8'h00;
    always @(posedge ref_clk) n_erase <= rst_n ? n_erase + {7'h00, erase} : 8'h00;
    always @(posedge done) chk("scan_out", q_exp.pop_front(), cap);

    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        close_out();
    end

    initial begin
        d = $random(seed);
        {pad_in, keeper_en, core_out} = d[23:0];
        user_code = $random(seed);
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        // request pin lies outside this block; the board holds it low
        repeat (4) @(negedge ref_clk);
        q_exp.push_back({`ID_VERSION, `ID_PART, `ID_MAKER, `ID_LSB});
        i_scan_tester.dr(32, 32'h0);
        // status pin is tied high, so the io setup code may be issued
        q_exp.push_back(32'h0);
        i_scan_tester.ir(`CODE_IO_SETUP);
        i_scan_tester.dr(8, d);
        chk("abort", 32'h1, {24'h0, n_abort});
        chk("io_open", 32'h1, {31'h0, io_open});
        chk("io_shift", 32'h8, {24'h0, n_shift});
        chk("io_data", {31'h0, d[7]}, {31'h0, io_data});
        chk("tdo_oe", 32'h0, {31'h0, oe_tdo});
        q_exp.push_back(user_code);
        i_scan_tester.ir(`CODE_USERCODE);
        i_scan_tester.dr(32, 32'h0);
        {e, b} = '0;
        for (int i = 0; i < 8; i++) begin
            e[3*i +: 3] = {1'b1, core_out[i], pad_in[i]};
            b[3*i +: 3] = {1'b1, d[24+i], 1'b0};
        end
        q_exp.push_back(e);
        i_scan_tester.ir(`CODE_SAMPLE);
        i_scan_tester.dr(24, b);
        // the preloaded cells drive the pins under clamp
        foreach (codes[k]) begin
            q_exp.push_back({24'h0, b[6:0], 1'b0});
            i_scan_tester.ir(codes[k]);
            i_scan_tester.dr(8, b);
            chk("oe", {24'h0, k == 1 ? 8'h00 : 8'hFF}, {24'h0, pad_oe});
            chk("keep", {24'h0, k == 1 ? keeper_en : 8'h00}, {24'h0, pad_keep});
            chk("out", {24'h0, k == 0 ? d[31:24] : k == 1 ? 8'h00 : core_out},
                {24'h0, pad_out});
        end
        chk("pulses", 32'h0, {24'h0, n_pulse});
        // plain variant refuses unlock and key load: no erase, no key
        chk("key", 32'h0, {22'h0, key_valid, |volatile_key, n_erase});
        i_scan_tester.ir(`CODE_CLK_USER);
        chk("clk_sel", 32'h1, {31'h0, clk_sel});
        i_scan_tester.ir(`CODE_IDLE);
        chk("ctl_idle", 32'h1, {31'h0, ctl_idle});
        i_scan_tester.ir(`CODE_CLK_OSC);
        i_scan_tester.ir(`CODE_ENGAGE);
        chk("clk_idle", 32'h0, {30'h0, clk_sel, ctl_idle});
        q_exp.push_back(32'h0);
        i_scan_tester.ir(`CODE_BOOT);
        i_scan_tester.dr(22, d);
        chk("boot_addr", {10'h0, d[21:0]}, {10'h0, boot_addr});
        chk("boot_load", 32'h1, {24'h0, n_load});
        i_scan_tester.ir(`CODE_RECONFIG);
        chk("pulses", 32'h1, {24'h0, n_pulse});
        close_out();
    end
endmodule
